// [hdl/ssp_consts.svh]
// constants of the synchronous serial port: formats, fifo sizes, timing
// assumes inclusion by the package, the port module and the bench only
// Notes on behaviour
// - one core works as bus master or as bus slave, picked by configuration.
// - frames carry four to sixteen data bits, picked by configuration.
// - transmit and receive fifos each hold eight frames.
// - every frame moves one word out and one word in at once.
// - a transfer involves exactly one master and one slave; others stay off.
// - the master makes the serial clock; a slave shifts on the received clock.
// - clock level selectable in spi format; other formats use active-high clock.
// - as master the serial clock toggles only during a frame.
// - outside frames the clock idles at its inactive level or is released.
// - as master the select goes active before the first data bit.
// - as master the select returns inactive once the data is sent (spi, third) or after the setup half-period (sync).
// - select polarity follows the format: low for spi and third, high for sync.
// - as slave the incoming select decides when master data is valid.
// - a selected slave shifts its transmit word out on the master-in line.
// - as master incoming data is sampled from the master-in line.
// - in spi and third format an unselected slave leaves the master-in line undriven; in sync format an enabled slave always drives it.
// - as master outgoing data is driven on the master-out line.
// - as slave incoming data is sampled from the master-out line.
// - three formats: spi, four-wire frame sync, third format with select.
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH
`define SSP_FMT_SPI    2'h0
`define SSP_FMT_SYNC   2'h1
`define SSP_FMT_THIRD  2'h2
`define SSP_WORD_W     16
`define SSP_FIFO_DEPTH 8
`define SSP_PTR_W      3
`define SSP_CNT_W      4
`define SSP_HALF_CYC   4
`define SSP_HALF_W     8
`define SSP_BIT_W      5
`define SSP_WAIT_MAX   600
`endif

// [hdl/ssp_pkg.sv]
// types shared by the synchronous serial port
// assumes the constants header sits beside it
`include "ssp_consts.svh"
package ssp_pkg;
  typedef logic [`SSP_WORD_W-1:0] word_t;
  // master sequencer, gray along idle-setup-xfer-hold
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_SETUP = 2'h1,
    ST_XFER  = 2'h3,
    ST_HOLD  = 2'h2
  } mstate_t;
  // static configuration, changed only while disabled
  typedef struct packed {
    logic       enable;
    logic       master_mode;
    logic [1:0] frame_format;
    logic [3:0] data_size_m1;
    logic       cpol;
    logic       cpha;
  } cfg_t;
  // pin drive group, enables low while driving
  typedef struct packed {
    logic serial_clock;
    logic serial_clock_oe_n;
    logic frame_select;
    logic frame_select_oe_n;
    logic master_out;
    logic master_out_oe_n;
    logic master_in_oe_n;
  } pin_out_t;
endpackage : ssp_pkg

// [hdl/sync_serial_port.sv]
// synchronous serial port: master/slave shifter with eight-frame fifos
// assumes static config while enabled; slave side runs on the received clock
`timescale 1ns/10ps
`include "ssp_consts.svh"
module sync_serial_port
  import ssp_pkg::*;
#(
  parameter int HALF_CYC = `SSP_HALF_CYC
) (
  input  wire logic     mclk,
  input  wire logic     rst_n,
  input  wire logic     serial_clock_link,
  input  wire cfg_t     cfg,
  input  wire logic     tx_valid,
  input  wire word_t    tx_data,
  output logic          tx_ready,
  output logic          rx_valid,
  output word_t         rx_data,
  input  wire logic     rx_ready,
  output logic          busy,
  input  wire logic     frame_select_pin_i,
  input  wire logic     master_in_pin_i,
  input  wire logic     master_out_pin_i,
  output pin_out_t      pins,
  output logic          master_in_pin_o
);
  localparam int DEPTH = `SSP_FIFO_DEPTH;
  localparam int WAIT_MAX = `SSP_WAIT_MAX;

  // decoded configuration
  wire logic       fmt_sync = (cfg.frame_format == `SSP_FMT_SYNC);
  wire logic       fmt_spi  = (cfg.frame_format == `SSP_FMT_SPI);
  wire logic       cpol_e   = fmt_spi & cfg.cpol;
  wire logic       cpha_e   = fmt_spi ? cfg.cpha : fmt_sync;
  wire logic [3:0] dss      = (cfg.data_size_m1 < 4'h3) ? 4'h3 : cfg.data_size_m1;
  wire logic [4:0] last_h   = {dss, 1'b1};
  wire logic       master   = cfg.master_mode;

  // ---------------- link domain: slave shifter ----------------
  word_t          stx_word_ff;
  word_t          lrx_ff;
  word_t          lword_ff;
  logic [3:0]     lcnt_ff;
  logic           lrun_ff;
  logic           ltgl_ff;
  logic           lmiso_ff;

  // select idle clears the shifter for spi and third format
  wire logic lclr     = !rst_n | (!fmt_sync & frame_select_pin_i);
  wire logic lshift   = !fmt_sync | (lrun_ff & !frame_select_pin_i);
  wire logic ldone    = lshift & (lcnt_ff == dss);

  // sample master-out on rising edge of the received clock
  always_ff @(posedge serial_clock_link or posedge lclr) begin
    if (lclr) begin
      lcnt_ff <= '0;
      lrx_ff  <= '0;
      lrun_ff <= 1'b0;
    end else if (fmt_sync & frame_select_pin_i) begin
      lcnt_ff <= '0;
      lrun_ff <= 1'b1;
    end else if (lshift) begin
      lrx_ff  <= {lrx_ff[`SSP_WORD_W-2:0], master_out_pin_i};
      lcnt_ff <= ldone ? 4'h0 : lcnt_ff + 4'h1;
      lrun_ff <= lrun_ff & !ldone;
    end
  end

  // completed word held stable, toggle flags it to mclk
  always_ff @(posedge serial_clock_link or negedge rst_n) begin
    if (!rst_n) begin
      ltgl_ff  <= 1'b0;
      lword_ff <= '0;
    end else if (ldone) begin
      ltgl_ff  <= ~ltgl_ff;
      lword_ff <= {lrx_ff[`SSP_WORD_W-2:0], master_out_pin_i};
    end
  end

  // launch slave data on falling edge, msb first
  always_ff @(negedge serial_clock_link or posedge lclr) begin
    if (lclr) begin
      lmiso_ff <= 1'b0;
    end else begin
      lmiso_ff <= stx_word_ff[dss - lcnt_ff];
    end
  end
  assign master_in_pin_o = lmiso_ff;

  // ---------------- pin synchronisers into mclk ----------------
  localparam int NSYNC = 3;
  wire logic [NSYNC-1:0] async_in = {ltgl_ff, frame_select_pin_i, master_in_pin_i};
  logic [NSYNC-1:0] s1_ff;
  logic [NSYNC-1:0] s2_ff;
  logic [NSYNC-1:0] s3_ff;
  logic [NSYNC-1:0] stab_ff;
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      // change accepted once stage two and three agree
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          s1_ff[gi]   <= 1'b0;
          s2_ff[gi]   <= 1'b0;
          s3_ff[gi]   <= 1'b0;
          stab_ff[gi] <= (gi == 1);
        end else begin
          s1_ff[gi]   <= async_in[gi];
          s2_ff[gi]   <= s1_ff[gi];
          s3_ff[gi]   <= s2_ff[gi];
          stab_ff[gi] <= (s2_ff[gi] == s3_ff[gi]) ? s3_ff[gi] : stab_ff[gi];
        end
      end
    end
  endgenerate
  wire logic miso_s = stab_ff[0];
  wire logic sel_s  = stab_ff[1];
  logic      tgl_seen_ff;
  wire logic sdone  = (stab_ff[2] != tgl_seen_ff);

  // ---------------- transmit fifo ----------------
  word_t                 tx_mem [DEPTH];
  logic [`SSP_PTR_W-1:0] tx_wp_ff;
  logic [`SSP_PTR_W-1:0] tx_rp_ff;
  logic [`SSP_CNT_W-1:0] tx_cnt_ff;
  logic                  tx_ready_ff;
  word_t                 rx_mem [DEPTH];
  logic [`SSP_PTR_W-1:0] rx_wp_ff;
  logic [`SSP_PTR_W-1:0] rx_rp_ff;
  logic [`SSP_CNT_W-1:0] rx_cnt_ff;
  mstate_t               st_ff;
  logic                  stx_have_ff;

  wire logic       tx_push  = tx_valid & tx_ready_ff;
  wire logic       rx_room  = (rx_cnt_ff != DEPTH[`SSP_CNT_W-1:0]);
  wire logic       m_load   = cfg.enable & master & (st_ff == ST_IDLE) & (tx_cnt_ff != '0) & rx_room;
  wire logic       s_load   = cfg.enable & !master & !stx_have_ff & (tx_cnt_ff != '0);
  wire logic       tx_pop   = m_load | s_load;
  wire word_t      tx_head  = tx_mem[tx_rp_ff];
  wire logic [3:0] nxt_tx_cnt = tx_cnt_ff + {3'h0, tx_push} - {3'h0, tx_pop};

  // transmit fifo storage and pointers
  always_ff @(posedge mclk) begin
    if (tx_push) tx_mem[tx_wp_ff] <= tx_data;
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tx_wp_ff    <= '0;
      tx_rp_ff    <= '0;
      tx_cnt_ff   <= '0;
      tx_ready_ff <= 1'b0;
    end else begin
      tx_wp_ff    <= tx_wp_ff + {2'h0, tx_push};
      tx_rp_ff    <= tx_rp_ff + {2'h0, tx_pop};
      tx_cnt_ff   <= nxt_tx_cnt;
      tx_ready_ff <= (nxt_tx_cnt != DEPTH[`SSP_CNT_W-1:0]);
    end
  end
  assign tx_ready = tx_ready_ff;

  // slave transmit word: held stable for the link side until a frame ends
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stx_word_ff <= '0;
      stx_have_ff <= 1'b0;
      tgl_seen_ff <= 1'b0;
    end else begin
      tgl_seen_ff <= stab_ff[2];
      if (s_load) stx_word_ff <= tx_head;
      stx_have_ff <= (stx_have_ff & !sdone) | s_load;                  // load wins over frame end
    end
  end

  // ---------------- master sequencer ----------------
  logic [`SSP_HALF_W-1:0] hdiv_ff;
  logic [`SSP_BIT_W-1:0]  hcnt_ff;
  logic                   sclk_ff;
  logic                   sel_act_ff;
  logic                   mosi_ff;
  word_t                  tx_sr_ff;
  word_t                  rx_sr_ff;

  wire logic  half_end = (hdiv_ff == HALF_CYC[`SSP_HALF_W-1:0] - 8'h01);
  wire logic  h_odd    = hcnt_ff[0];
  wire logic  x_end    = (st_ff == ST_XFER) & half_end;
  wire logic  emit     = x_end & (cpha_e ? !h_odd : (h_odd & (hcnt_ff != last_h)));
  wire logic  capture  = x_end & (cpha_e ? (!h_odd & (hcnt_ff != '0)) : h_odd);
  wire logic  m_push   = (st_ff == ST_HOLD) & half_end;
  wire word_t m_word   = cpha_e ? {rx_sr_ff[`SSP_WORD_W-2:0], miso_s} : rx_sr_ff;

  // half-period divider and state
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_ff   <= ST_IDLE;
      hdiv_ff <= '0;
      hcnt_ff <= '0;
    end else begin
      hdiv_ff <= (st_ff == ST_IDLE || half_end) ? '0 : hdiv_ff + 8'h01;
      case (st_ff)
        ST_IDLE:  if (m_load) st_ff <= ST_SETUP;
        ST_SETUP: if (half_end) st_ff <= ST_XFER;
        ST_XFER: begin
          if (half_end) hcnt_ff <= hcnt_ff + 5'h01;
          if (half_end && hcnt_ff == last_h) st_ff <= ST_HOLD;
        end
        default: if (half_end) begin
          st_ff   <= ST_IDLE;
          hcnt_ff <= '0;
        end
      endcase
    end
  end

  // clock, select and data shifting of the master
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sclk_ff    <= 1'b0;
      sel_act_ff <= 1'b0;
      mosi_ff    <= 1'b0;
      tx_sr_ff   <= '0;
      rx_sr_ff   <= '0;
    end else if (m_load) begin
      sclk_ff    <= cpol_e;
      sel_act_ff <= 1'b1;
      mosi_ff    <= !cpha_e & tx_head[dss];
      tx_sr_ff   <= cpha_e ? tx_head : (tx_head << 1);
      rx_sr_ff   <= '0;
    end else begin
      if (x_end) sclk_ff <= ~sclk_ff;
      if ((st_ff == ST_SETUP && half_end && fmt_sync) || m_push) sel_act_ff <= 1'b0;
      if (emit) begin
        mosi_ff  <= tx_sr_ff[dss];
        tx_sr_ff <= tx_sr_ff << 1;
      end
      if (capture) rx_sr_ff <= {rx_sr_ff[`SSP_WORD_W-2:0], miso_s};
      if (st_ff == ST_IDLE) sclk_ff <= cpol_e;
    end
  end

  // ---------------- receive fifo ----------------
  wire logic  rx_push  = m_push | (sdone & !master);
  wire word_t rx_in    = master ? m_word : lword_ff;
  wire logic  out_free = !rx_valid | rx_ready;
  wire logic  rx_pop   = out_free & (rx_cnt_ff != '0);
  wire logic  rx_wr    = rx_push & rx_room;
  logic       rx_valid_ff;
  word_t      rx_data_ff;

  always_ff @(posedge mclk) begin
    if (rx_wr) rx_mem[rx_wp_ff] <= rx_in;
  end
  // pointers and registered output stage
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rx_wp_ff    <= '0;
      rx_rp_ff    <= '0;
      rx_cnt_ff   <= '0;
      rx_valid_ff <= 1'b0;
      rx_data_ff  <= '0;
    end else begin
      rx_wp_ff  <= rx_wp_ff + {2'h0, rx_wr};
      rx_rp_ff  <= rx_rp_ff + {2'h0, rx_pop};
      rx_cnt_ff <= rx_cnt_ff + {3'h0, rx_wr} - {3'h0, rx_pop};
      if (out_free) rx_valid_ff <= (rx_cnt_ff != '0);
      if (rx_pop) rx_data_ff <= rx_mem[rx_rp_ff];
    end
  end
  assign rx_valid = rx_valid_ff;
  assign rx_data  = rx_data_ff;

  // ---------------- pin drive ----------------
  pin_out_t  pins_ff;
  logic      busy_ff;
  wire logic sel_level   = fmt_sync ? sel_act_ff : !sel_act_ff;
  wire logic slv_sel     = fmt_sync | !sel_s;
  pin_out_t  nxt_pins;
  assign nxt_pins.serial_clock      = sclk_ff;
  assign nxt_pins.serial_clock_oe_n = !master;
  assign nxt_pins.frame_select      = sel_level;
  assign nxt_pins.frame_select_oe_n = !master;
  assign nxt_pins.master_out        = mosi_ff;
  assign nxt_pins.master_out_oe_n   = !master;
  assign nxt_pins.master_in_oe_n    = master | !cfg.enable | !slv_sel;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pins_ff <= '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
      busy_ff <= 1'b0;
    end else begin
      pins_ff <= nxt_pins;
      busy_ff <= (st_ff != ST_IDLE) | (tx_cnt_ff != '0);
    end
  end
  assign pins = pins_ff;
  assign busy = busy_ff;

  // ---------------- checks ----------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_clock_quiet: assert property ((st_ff == ST_SETUP || st_ff == ST_HOLD) |=> $stable(sclk_ff))
    else $error("serial clock moved outside a frame");
  chk_sel_lead: assert property (st_ff == ST_SETUP && !fmt_sync |=> pins_ff.frame_select == 1'b0)
    else $error("select not active before first bit");
  chk_sel_release: assert property (m_push && !fmt_sync |=> !sel_act_ff ##1 pins_ff.frame_select)
    else $error("select not released after frame");
  chk_frame_end: assert property (x_end && hcnt_ff == last_h |=> st_ff == ST_HOLD && sclk_ff == cpol_e)
    else $error("frame length or idle clock level wrong");
  chk_fifo_full: assert property (tx_cnt_ff == DEPTH[`SSP_CNT_W-1:0] |-> !tx_ready_ff)
    else $error("transmit fifo accepts while full");
  chk_fifo_bound: assert property (tx_cnt_ff <= DEPTH[`SSP_CNT_W-1:0] && rx_cnt_ff <= DEPTH[`SSP_CNT_W-1:0])
    else $error("fifo count beyond depth");
  chk_duplex_word: assert property (m_load |-> ##[1:WAIT_MAX] m_push)
    else $error("loaded frame returned no received word");
  chk_slave_quiet: assert property (!master && !slv_sel |=> pins_ff.master_in_oe_n)
    else $error("unselected slave drives master-in");
  chk_slave_clock: assert property (!master |=> pins_ff.serial_clock_oe_n && pins_ff.frame_select_oe_n)
    else $error("slave drives clock or select");
  chk_master_drive: assert property (master ##1 master |-> !pins_ff.master_out_oe_n && pins_ff.master_in_oe_n)
    else $error("master pin drive wrong");
  chk_idle_clock: assert property (st_ff == ST_IDLE ##1 st_ff == ST_IDLE |-> sclk_ff == $past(cpol_e))
    else $error("idle serial clock not at inactive level");
endmodule : sync_serial_port

// [dv/spi_far_end.sv]
// far-side model: remote slave for master frames, remote master for slave frames
// assumes the bench routes the shared wires and sets the mode inputs between frames
`timescale 1ns/10ps
module spi_far_end
  import ssp_pkg::*;
(
  input  wire logic       dev_clk,
  input  wire logic       dev_sel,
  input  wire logic       dev_mosi,
  input  wire logic       dev_miso,
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic       sync_fmt,
  input  wire logic [4:0] nbits,
  output logic            far_miso,
  output logic            link_clk,
  output logic            link_sel,
  output logic            link_mosi
);
  word_t reply_q[$];
  word_t got_q[$];
  word_t reply_w;
  word_t got_w;
  int    idx = 0;
  int    cnt = 0;
  // idle levels: clock stands high, select inactive
  initial begin
    far_miso  = 1'h0;
    link_clk  = 1'h1;
    link_sel  = 1'h1;
    link_mosi = 1'h0;
  end
  // load the reply word when this slave is selected
  task automatic start_frame();
    reply_w = 16'h0000;
    if (reply_q.size() > 0) reply_w = reply_q.pop_front();
    got_w = 16'h0000;
    cnt   = int'(nbits);
    idx   = cpha ? int'(nbits) : int'(nbits) - 1;
    if (!cpha && cnt > 0) far_miso = reply_w[idx];
  endtask : start_frame
  // select starts a frame; a released line never keeps the last bit
  always @(negedge dev_sel) if (!sync_fmt) start_frame();
  always @(posedge dev_sel) begin
    if (sync_fmt) start_frame();
    else far_miso = ~far_miso;
  end
  // shift on one clock edge, sample the other
  always @(dev_clk) begin
    if (cnt > 0 && !$isunknown(dev_clk)) begin
      if ((dev_clk != cpol) == cpha) begin
        if (idx > 0) begin
          idx      = idx - 1;
          far_miso = reply_w[idx];
        end
      end else begin
        got_w = {got_w[14:0], dev_mosi};
        cnt   = cnt - 1;
        if (cnt == 0) begin
          got_q.push_back(got_w);
          if (sync_fmt) far_miso <= #40 ~far_miso;
        end
      end
    end
  end
  // remote master frame; clock runs only inside it
  task automatic run_master(input word_t w, input int n, input logic sel, output word_t got);
    got      = 16'h0000;
    link_sel = ~sel;
    #60;
    for (int i = n - 1; i >= 0; i--) begin
      link_clk  = 1'h0;
      link_mosi = w[i];
      #3;
      link_clk = 1'h1;
      got      = {got[14:0], dev_miso};
      #3;
    end
    #9;
    link_sel  = 1'h1;
    link_mosi = ~link_mosi;  // no stale bit once released
  endtask : run_master
endmodule : spi_far_end

// [dv/tb_top.sv]
// bench: master frames in every format, fifo fill and drain, slave frames
// assumes the far-side model and the design package and header
`timescale 1ns/10ps
`include "ssp_consts.svh"
module tb_top
  import ssp_pkg::*;
;
  localparam int HC = 4;
  logic       mclk = 1'h0;
  logic       rst_n = 1'h0;
  cfg_t       cfg;
  logic       tx_valid, rx_ready, tx_ready, rx_valid, busy, mi_o, far_miso;
  logic       link_clk, link_sel, link_mosi, m_cpol, m_cpha, m_sync, sel_early;
  logic [4:0] m_bits;
  word_t      tx_data, rx_data;
  pin_out_t   pins;
  wire logic  ck_w, sel_w, mo_w, mi_w;
  int         err_count = 0;
  int         checked = 0;
  int         edges = 0;
  // system clock
  always #5 mclk = ~mclk;
  // wire levels from whichever party drives
  assign ck_w  = pins.serial_clock_oe_n ? link_clk : pins.serial_clock;
  assign sel_w = pins.frame_select_oe_n ? link_sel : pins.frame_select;
  assign mo_w  = pins.master_out_oe_n ? link_mosi : pins.master_out;
  assign mi_w  = pins.master_in_oe_n ? far_miso : mi_o;
  sync_serial_port #(.HALF_CYC(HC)) dut (
    .mclk(mclk), .rst_n(rst_n), .serial_clock_link(link_clk), .cfg(cfg), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .busy(busy), .frame_select_pin_i(sel_w), .master_in_pin_i(mi_w), .master_out_pin_i(mo_w),
    .pins(pins), .master_in_pin_o(mi_o)
  );
  spi_far_end far (
    .dev_clk(ck_w), .dev_sel(sel_w), .dev_mosi(mo_w), .dev_miso(mi_w), .cpol(m_cpol), .cpha(m_cpha),
    .sync_fmt(m_sync), .nbits(m_bits), .far_miso(far_miso), .link_clk(link_clk), .link_sel(link_sel),
    .link_mosi(link_mosi)
  );
  // clock toggles, and an active select before the first toggle
  always @(pins.serial_clock) if (rst_n) edges++;
  always @(posedge mclk) if (edges == 0 && sel_w === m_sync) sel_early <= 1'h1;
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task automatic cmp(input word_t got, input word_t exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic cmp_bit(input logic got, input logic exp);
    cmp({15'h0000, got}, {15'h0000, exp});
  endtask : cmp_bit
  // bounded wait for a flag level
  task automatic wait_lvl(ref logic f, input logic v);
    int n;
    n = 0;
    while (f !== v && n < 3000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (f !== v) begin
      cmp_bit(f, v);
      end_sim();
    end
  endtask : wait_lvl
  task automatic set_cfg(input logic ms, input logic [1:0] fmt, input int n, input logic pol, input logic pha);
    @(posedge mclk);
    cfg    <= '{1'h0, ms, fmt, 4'(n - 1), pol, pha};
    m_cpol <= (fmt == `SSP_FMT_SPI) ? pol : 1'h0;
    m_cpha <= pha;
    m_sync <= (fmt == `SSP_FMT_SYNC);
    m_bits <= ms ? 5'(n) : 5'h00;
    repeat (4) @(posedge mclk);
    cfg.enable <= 1'h1;
    repeat (4) @(posedge mclk);
    #1;
  endtask : set_cfg
  task automatic push(input word_t w);
    @(posedge mclk);
    tx_valid <= 1'h1;
    tx_data  <= w;
    #1;
    cmp_bit(tx_ready, 1'h1);
    @(posedge mclk);
    tx_valid <= 1'h0;
  endtask : push
  task automatic pop(input word_t exp, input word_t msk);
    wait_lvl(rx_valid, 1'h1);
    cmp(rx_data & msk, exp & msk);
    @(posedge mclk);
    rx_ready <= 1'h1;
    @(posedge mclk);
    rx_ready <= 1'h0;
    repeat (2) @(posedge mclk);
    #1;
  endtask : pop
  task automatic reset_idle();
    @(posedge mclk);
    #1;
    cmp_bit(pins.serial_clock, 1'h0);
    cmp_bit(pins.serial_clock_oe_n, 1'h0);
    cmp_bit(pins.frame_select, 1'h1);
    cmp_bit(pins.master_in_oe_n, 1'h1);
    cmp_bit(rx_valid, 1'h0);
    cmp_bit(busy, 1'h0);
    repeat (3) @(posedge mclk);
    #1;
    cmp_bit(tx_ready, 1'h1);
  endtask : reset_idle
  // one master frame: duplex data, toggle count, select and idle levels
  task automatic master_frame(input logic [1:0] fmt, input logic pol, input logic pha, input int n,
                              input word_t w, input word_t r);
    word_t msk;
    msk = word_t'((32'h1 << n) - 1);
    set_cfg(1'h1, fmt, n, pol, pha);
    cmp_bit(pins.serial_clock, (fmt == `SSP_FMT_SPI) ? pol : 1'h0);
    cmp_bit(sel_w, fmt != `SSP_FMT_SYNC);
    far.reply_q.push_back(r);
    edges     = 0;
    sel_early = 1'h0;
    push(w);
    pop(r, msk);
    wait_lvl(busy, 1'h0);
    cmp(far.got_q.pop_front() & msk, w & msk);
    cmp(word_t'(edges), word_t'(2 * n));
    cmp_bit(sel_early, 1'h1);
    cmp_bit(sel_w, fmt != `SSP_FMT_SYNC);
  endtask : master_frame
  // transmit fifo fills to eight while disabled, then drains with no pops
  task automatic fill_drain();
    int n;
    logic rdy;
    set_cfg(1'h1, `SSP_FMT_SPI, 8, 1'h0, 1'h0);
    @(posedge mclk);
    cfg.enable <= 1'h0;
    tx_valid   <= 1'h1;
    tx_data    <= 16'h00A0;
    n = 0;
    repeat (12) begin
      #1;
      rdy = tx_ready;
      @(posedge mclk);
      if (rdy === 1'h1) begin
        n++;
        tx_data <= 16'h00A0 + word_t'(n);
      end
    end
    tx_valid <= 1'h0;
    cmp(word_t'(n), 16'h0008);
    for (int i = 0; i < 8; i++) far.reply_q.push_back(16'h0050 + word_t'(i));
    cfg.enable <= 1'h1;
    wait_lvl(busy, 1'h0);
    for (int i = 0; i < 8; i++) begin
      pop(16'h0050 + word_t'(i), 16'h00FF);
      cmp(far.got_q.pop_front(), 16'h00A0 + word_t'(i));
    end
    cmp_bit(rx_valid, 1'h0);
  endtask : fill_drain
  // slave: ignores an unselected frame, answers a selected one
  task automatic slave_frames();
    word_t got;
    set_cfg(1'h0, `SSP_FMT_SPI, 16, 1'h1, 1'h1);
    push(16'hC35A);
    repeat (8) @(posedge mclk);
    #1;
    cmp_bit(pins.master_in_oe_n, 1'h1);
    cmp_bit(pins.serial_clock_oe_n, 1'h1);
    far.run_master(16'h9E71, 16, 1'h0, got);
    repeat (16) @(posedge mclk);
    #1;
    cmp_bit(rx_valid, 1'h0);
    far.run_master(16'h3B4D, 16, 1'h1, got);
    cmp(got, 16'hC35A);
    pop(16'h3B4D, 16'hFFFF);
    cmp_bit(pins.master_in_oe_n, 1'h1);
  endtask : slave_frames
  // main sequence
  initial begin
    cfg       = '{1'h0, 1'h1, `SSP_FMT_SPI, 4'h7, 1'h0, 1'h0};
    tx_valid  = 1'h0;
    tx_data   = 16'h0000;
    rx_ready  = 1'h0;
    m_cpol    = 1'h0;
    m_cpha    = 1'h0;
    m_sync    = 1'h0;
    m_bits    = 5'h08;
    sel_early = 1'h0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'h1;
    reset_idle();
    master_frame(`SSP_FMT_SPI, 1'h0, 1'h0, 16, 16'hA5C3, 16'h5A3C);
    master_frame(`SSP_FMT_SPI, 1'h1, 1'h1, 4, 16'h0009, 16'h0006);
    master_frame(`SSP_FMT_SPI, 1'h1, 1'h0, 9, 16'h0135, 16'h00CA);
    master_frame(`SSP_FMT_SYNC, 1'h0, 1'h1, 8, 16'h00B4, 16'h004B);
    master_frame(`SSP_FMT_THIRD, 1'h0, 1'h0, 8, 16'h0072, 16'h008D);
    fill_drain();
    slave_frames();
    end_sim();
  end
endmodule : tb_top
